// ---- inc/mpr_defs.svh ----
// offsets, field positions, reset values and timing counts for the mpr link
`ifndef MPR_DEFS_SVH
`define MPR_DEFS_SVH
// Contract
// - four 8-bit pattern locations, numbered 0 to 3
// - mpr mode allows only MRS RD WR DES REF
// - auto precharge ignored on mpr reads, writes
// - no power-down or self refresh in mpr
// - 1x refresh only, idle for tRFC after
// - finish mpr access before any refresh
// - mr3 write decode: command bits, bank, group
// - bank bits pick the location, group ignored
// - defaults 55, 33, 0F, 00 before writes
// - fixed BL8 or fixed BC4 only; the code also accepts the on-the-fly setting
// - BC4 starts at column 000 or 100
// - read column A1:A0 zero, A2 zero for BL8
// - on-the-fly setting forces A12 high on reads
// - data bus inversion stays off for reads
// - burst starts additive plus cas plus parity later
// - mr3 page and format bits pick return format
// - entry: dll on, precharge, tRP, mr3, tMOD
// - reads and writes go to patterns in mpr
// - exit: tMPRR, mr3 clear, tMOD before array
// - write loads A7:A0, A7 is first beat
// - wait write recovery after each mpr write
// - tCAL added to mode register delays
// - strobes driven with every read burst

// ****************************************
// clock and timing
// ****************************************
`define CLK_PS 5000
`define CYC(ns) ((((ns) * 1000) + `CLK_PS - 1) / `CLK_PS)
`define T_RP_NS 15
`define T_RP_CK `CYC(`T_RP_NS)
`define T_RFC_NS 200
`define T_RFC_CK `CYC(`T_RFC_NS)
`define T_MRD_CK 8
`define T_MOD_CK 24
`define T_CAL_CK 3
`define T_MPRR_CK 1
`define T_WR_MPR_CK 24
`define BURST_CK 8

// ****************************************
// pins and mode register fields
// ****************************************
`define MR0_SEL 4'h0
`define MR3_SEL 4'h3
`define MR3_MPR_EN 2
`define MR3_PAGE_HI 1
`define MR3_PAGE_LO 0
`define MR3_FMT_HI 12
`define MR3_FMT_LO 11
`define AUTO_PRE_BIT 10
`define BC_BIT 12
`define COL_HALF_BIT 2
`define BL_FIX8 2'h0
`define BL_OTF 2'h1
`define BL_BC4 2'h2
`define BL_BAD 2'h3
`define FMT_PARALLEL 2'h1
`define FMT_STAGGER 2'h2
`define PAT0_RST 8'h55
`define PAT1_RST 8'h33
`define PAT2_RST 8'h0F
`define PAT3_RST 8'h00

// ****************************************
// controller register map
// ****************************************
`define REG_CMD 4'h0
`define REG_CFG 4'h4
`define REG_STAT 4'h8
`define REG_RDATA 4'hC
`define CMD_OP_HI 2
`define CMD_OP_LO 0
`define CMD_LOC_HI 5
`define CMD_LOC_LO 4
`define CMD_HALF 6
`define CMD_DATA_HI 15
`define CMD_DATA_LO 8
`define CFG_BL_HI 1
`define CFG_BL_LO 0
`define CFG_FMT_HI 3
`define CFG_FMT_LO 2
`define CFG_CAL 4
`define CFG_DLL 5
`define CFG_RL_HI 13
`define CFG_RL_LO 8
`define STAT_BUSY 0
`define STAT_MPR 1
`define STAT_REFUSED 2
`endif

// ---- inc/mpr_pkg.sv ----
// shared types and command coding for the mpr training link
`default_nettype none
package mpr_pkg;
  typedef logic [3:0][7:0] pat_arr_t;
  typedef struct packed {
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } cmd_t;
  typedef enum logic [2:0] {
    K_DES = 3'h0,
    K_MRS = 3'h1,
    K_REF = 3'h2,
    K_PRE = 3'h3,
    K_RD = 3'h4,
    K_WR = 3'h5,
    K_ACT = 3'h6,
    K_OTHER = 3'h7
  } cmd_kind_t;
  typedef enum logic [2:0] {
    OP_ENTER = 3'h0,
    OP_EXIT = 3'h1,
    OP_READ = 3'h2,
    OP_WRITE = 3'h3,
    OP_REFRESH = 3'h4,
    OP_MR0 = 3'h5
  } op_t;

  function automatic cmd_kind_t cmd_dec(input cmd_t c);
    cmd_kind_t k;
    k = K_OTHER;
    if (c.cs_n) begin
      k = K_DES;
    end else if (!c.act_n) begin
      k = K_ACT;
    end else begin
      case ({c.ras_n, c.cas_n, c.we_n})
        3'h0: k = K_MRS;
        3'h1: k = K_REF;
        3'h2: k = K_PRE;
        3'h5: k = K_RD;
        3'h4: k = K_WR;
        default: k = K_OTHER;
      endcase
    end
    return k;
  endfunction : cmd_dec

  function automatic cmd_t cmd_enc(input cmd_kind_t k);
    cmd_t c;
    case (k)
      K_MRS: c = 5'h08;
      K_REF: c = 5'h09;
      K_PRE: c = 5'h0A;
      K_RD: c = 5'h0D;
      K_WR: c = 5'h0C;
      K_ACT: c = 5'h07;
      default: c = 5'h1F;
    endcase
    return c;
  endfunction : cmd_enc
endpackage : mpr_pkg
`default_nettype wire

// ---- inc/mpr_link_if.sv ----
// command, address and data wires between controller and dram ends
`timescale 1ns/1ps
`default_nettype none
interface mpr_link_if;
  logic cke;
  logic cs_n;
  logic act_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] bg;
  logic [1:0] ba;
  logic [13:0] addr;
  logic [7:0] dq_o;
  logic dq_oe;
  logic dqs_o;
  logic dqs_oe;
  logic [7:0] dq;
  logic dqs;
  logic dqs_act;
  // termination pulls undriven lines high
  assign dq = dq_oe ? dq_o : 8'hFF;
  assign dqs = dqs_oe ? dqs_o : 1'b1;
  assign dqs_act = dqs_oe;
  modport ctrl (output cke, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr,
                input dq, dqs, dqs_act);
  modport dram (input cke, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr,
                output dq_o, dq_oe, dqs_o, dqs_oe);
endinterface : mpr_link_if
`default_nettype wire

// ---- src/mpr_pattern_regs.sv ----
// four training pattern locations with reset defaults
`timescale 1ns/1ps
`default_nettype none
`include "mpr_defs.svh"
module mpr_pattern_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [1:0] wr_loc,
  input wire logic [7:0] wr_data,
  output mpr_pkg::pat_arr_t pats
);
  mpr_pkg::pat_arr_t pats_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pats_r <= {`PAT3_RST, `PAT2_RST, `PAT1_RST, `PAT0_RST};
    end else if (wr_en) begin
      pats_r[wr_loc] <= wr_data;
    end
  end

  assign pats = pats_r;
endmodule : mpr_pattern_regs
`default_nettype wire

// ---- src/mpr_dram_end.sv ----
// dram end: mr3 decode, pattern writes and latency-timed read bursts
`timescale 1ns/1ps
`default_nettype none
`include "mpr_defs.svh"
module mpr_dram_end (
  input wire logic clk,
  input wire logic nrst,
  mpr_link_if.dram link,
  input wire logic [4:0] cas_lat,
  input wire logic [4:0] add_lat,
  input wire logic [2:0] par_lat,
  input wire logic par_en,
  output logic mpr_on,
  output logic [1:0] fmt
);
  typedef enum logic [1:0] {
    R_IDLE = 2'h0,
    R_WAIT = 2'h1,
    R_BURST = 2'h2
  } rstate_t;

  mpr_pkg::cmd_kind_t kind;
  logic [3:0] sel;
  logic is_mr3;
  logic is_mr0;
  logic wr_hit;
  logic rd_hit;
  logic first;
  logic mpr_en_r;
  logic [1:0] page_r;
  logic [1:0] fmt_r;
  logic [1:0] bl_r;
  mpr_pkg::pat_arr_t pats;
  rstate_t rs_r;
  logic [6:0] lat_r;
  logic [6:0] rl;
  logic [2:0] ui_r;
  logic [3:0] left_r;
  logic [1:0] loc_r;
  logic [7:0] dq_r;
  logic oe_r;
  logic dqs_r;

  // ****************************************
  // beat formatting
  // ****************************************
  function automatic logic [7:0] beat_data(input mpr_pkg::pat_arr_t p,
      input logic [1:0] loc, input logic [1:0] f, input logic [1:0] pg,
      input logic [2:0] ui);
    logic [7:0] d;
    logic [2:0] bi;
    d = 8'h00;
    bi = 3'h7 - ui;
    for (int i = 0; i < 8; i++) begin
      // only page 0 holds patterns; other pages read as zero
      if (pg != 2'h0) begin
        d[i] = 1'b0;
      end else if (f == `FMT_PARALLEL) begin
        d[i] = p[loc][3'(7 - i)];
      end else if (f == `FMT_STAGGER) begin
        d[i] = p[2'(loc + 2'(i))][bi];
      end else begin
        d[i] = p[loc][bi];
      end
    end
    return d;
  endfunction : beat_data

  // ****************************************
  // command decode and mode
  // ****************************************
  assign kind = mpr_pkg::cmd_dec({link.cs_n, link.act_n, link.ras_n, link.cas_n, link.we_n});
  assign sel = {link.bg, link.ba};
  assign is_mr3 = kind == mpr_pkg::K_MRS && sel == `MR3_SEL;
  assign is_mr0 = kind == mpr_pkg::K_MRS && sel == `MR0_SEL;
  // a10 is never looked at, so auto precharge falls away
  assign wr_hit = mpr_en_r && kind == mpr_pkg::K_WR;
  assign rd_hit = mpr_en_r && kind == mpr_pkg::K_RD && rs_r == R_IDLE;
  assign rl = 7'({2'h0, add_lat}) + 7'({2'h0, cas_lat})
            + (par_en ? 7'({4'h0, par_lat}) : 7'h00);
  assign first = rs_r == R_WAIT && lat_r <= 7'h01;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mpr_en_r <= 1'b0;
      page_r <= 2'h0;
      fmt_r <= 2'h0;
    end else if (is_mr3) begin
      mpr_en_r <= link.addr[`MR3_MPR_EN];
      page_r <= link.addr[`MR3_PAGE_HI:`MR3_PAGE_LO];
      fmt_r <= link.addr[`MR3_FMT_HI:`MR3_FMT_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bl_r <= `BL_FIX8;
    end else if (is_mr0) begin
      bl_r <= link.addr[1:0];
    end
  end

  mpr_pattern_regs u_pats (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_hit),
    .wr_loc(link.ba),
    .wr_data(link.addr[7:0]),
    .pats(pats)
  );

  // ****************************************
  // read burst
  // ****************************************
  // one beat per clock; a read that lands mid-burst is dropped
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rs_r <= R_IDLE;
      lat_r <= 7'h00;
      ui_r <= 3'h0;
      left_r <= 4'h0;
      loc_r <= 2'h0;
    end else begin
      unique case (rs_r)
        R_IDLE: begin
          if (rd_hit) begin
            loc_r <= link.ba;
            ui_r <= (bl_r == `BL_BC4 && link.addr[`COL_HALF_BIT]) ? 3'h4 : 3'h0;
            left_r <= (bl_r == `BL_BC4) ? 4'h4 : 4'h8;
            lat_r <= rl - 7'h01;
            rs_r <= R_WAIT;
          end
        end
        R_WAIT: begin
          if (first) begin
            rs_r <= R_BURST;
          end else begin
            lat_r <= lat_r - 7'h01;
          end
        end
        R_BURST: begin
          ui_r <= ui_r + 3'h1;
          left_r <= left_r - 4'h1;
          if (left_r == 4'h1) begin
            rs_r <= R_IDLE;
          end
        end
        default: rs_r <= R_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dq_r <= 8'h00;
      oe_r <= 1'b0;
      dqs_r <= 1'b0;
    end else if (first) begin
      dq_r <= beat_data(pats, loc_r, fmt_r, page_r, ui_r);
      oe_r <= 1'b1;
      dqs_r <= ~ui_r[0];
    end else if (rs_r == R_BURST && left_r != 4'h1) begin
      dq_r <= beat_data(pats, loc_r, fmt_r, page_r, 3'(ui_r + 3'h1));
      dqs_r <= ui_r[0];
    end else begin
      oe_r <= 1'b0;
    end
  end

  assign link.dq_o = dq_r;
  assign link.dq_oe = oe_r;
  assign link.dqs_o = dqs_r;
  assign link.dqs_oe = oe_r;
  assign mpr_on = mpr_en_r;
  assign fmt = fmt_r;
endmodule : mpr_dram_end
`default_nettype wire

// ---- src/mpr_ctrl_end.sv ----
// controller end: runs mpr entry, reads, writes, refresh and exit
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mpr_defs.svh"
module mpr_ctrl_end (
  input wire logic clk,
  input wire logic nrst,
  mpr_link_if.ctrl link,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_WAIT = 2'h1
  } hstate_t;

  hstate_t state_r;
  mpr_pkg::op_t op_r;
  mpr_pkg::op_t op_sel;
  logic more_r;
  logic [7:0] cnt_r;
  logic [1:0] cfg_bl_r;
  logic [1:0] cfg_fmt_r;
  logic cfg_cal_r;
  logic cfg_dll_r;
  logic [5:0] cfg_rl_r;
  logic mpr_on_r;
  logic refused_r;
  logic [7:0] lane_r;
  logic [7:0] beat0_r;
  logic [3:0] beats_r;
  mpr_pkg::cmd_t cmd_r;
  logic [3:0] sel_r;
  logic [13:0] addr_r;
  logic ph_sel;
  mpr_pkg::cmd_kind_t s_kind;
  logic [3:0] s_sel;
  logic [13:0] s_addr;
  logic [7:0] s_wait;
  logic s_more;
  logic [7:0] mod_wait;
  logic wr_cmd;
  logic legal;
  logic accept;
  logic refuse;
  logic step_end;
  logic issue;

  // ****************************************
  // request decode
  // ****************************************
  assign wr_cmd = reg_wr && reg_addr == `REG_CMD;
  assign op_sel = (state_r == H_IDLE) ?
                  mpr_pkg::op_t'(reg_wdata[`CMD_OP_HI:`CMD_OP_LO]) : op_r;
  assign ph_sel = state_r == H_WAIT;
  assign step_end = state_r == H_WAIT && cnt_r == 8'h01;
  assign accept = wr_cmd && state_r == H_IDLE && legal;
  assign refuse = wr_cmd && !(state_r == H_IDLE && legal);
  assign issue = accept || (step_end && more_r);
  // tMOD already covers tMRD; cal adds the new setting's delay
  assign mod_wait = ((`T_MOD_CK > `T_MRD_CK) ? 8'(`T_MOD_CK) : 8'(`T_MRD_CK))
                  + (cfg_cal_r ? 8'(`T_CAL_CK) : 8'h00);

  always_comb begin
    legal = 1'b0;
    case (op_sel)
      mpr_pkg::OP_ENTER: legal = !mpr_on_r && cfg_dll_r;
      mpr_pkg::OP_EXIT: legal = mpr_on_r;
      mpr_pkg::OP_READ: legal = mpr_on_r;
      mpr_pkg::OP_WRITE: legal = mpr_on_r;
      // only taken when idle, so no mpr access is open
      mpr_pkg::OP_REFRESH: legal = 1'b1;
      mpr_pkg::OP_MR0: legal = cfg_bl_r != `BL_BAD;
      default: legal = 1'b0;
    endcase
  end

  // ****************************************
  // command builder
  // ****************************************
  always_comb begin
    s_kind = mpr_pkg::K_DES;
    s_sel = 4'h0;
    s_addr = 14'h0000;
    s_wait = 8'h01;
    s_more = 1'b0;
    case (op_sel)
      mpr_pkg::OP_ENTER: begin
        if (!ph_sel) begin
          s_kind = mpr_pkg::K_PRE;
          s_addr[`AUTO_PRE_BIT] = 1'b1;
          s_wait = 8'(`T_RP_CK);
          s_more = 1'b1;
        end else begin
          // mode register 5 is never written, so dbi stays off
          s_kind = mpr_pkg::K_MRS;
          s_sel = `MR3_SEL;
          s_addr[`MR3_MPR_EN] = 1'b1;
          s_addr[`MR3_FMT_HI:`MR3_FMT_LO] = cfg_fmt_r;
          s_wait = mod_wait;
        end
      end
      mpr_pkg::OP_EXIT: begin
        if (!ph_sel) begin
          s_wait = 8'(`T_MPRR_CK);
          s_more = 1'b1;
        end else begin
          s_kind = mpr_pkg::K_MRS;
          s_sel = `MR3_SEL;
          s_addr[`MR3_FMT_HI:`MR3_FMT_LO] = cfg_fmt_r;
          s_wait = mod_wait;
        end
      end
      mpr_pkg::OP_READ: begin
        s_kind = mpr_pkg::K_RD;
        s_sel = {2'h0, reg_wdata[`CMD_LOC_HI:`CMD_LOC_LO]};
        // column bits 1:0 stay zero; bit 2 only for fixed chop
        s_addr[`COL_HALF_BIT] = reg_wdata[`CMD_HALF] && cfg_bl_r == `BL_BC4;
        s_addr[`BC_BIT] = cfg_bl_r == `BL_OTF;
        s_wait = 8'({2'h0, cfg_rl_r}) + 8'(`BURST_CK) + 8'h01;
      end
      mpr_pkg::OP_WRITE: begin
        s_kind = mpr_pkg::K_WR;
        s_sel = {2'h0, reg_wdata[`CMD_LOC_HI:`CMD_LOC_LO]};
        s_addr[7:0] = reg_wdata[`CMD_DATA_HI:`CMD_DATA_LO];
        s_wait = 8'(`T_WR_MPR_CK);
      end
      mpr_pkg::OP_REFRESH: begin
        // fine granularity is never programmed, so refresh is 1x
        s_kind = mpr_pkg::K_REF;
        s_wait = 8'(`T_RFC_CK);
      end
      mpr_pkg::OP_MR0: begin
        s_kind = mpr_pkg::K_MRS;
        s_sel = `MR0_SEL;
        s_addr[1:0] = cfg_bl_r;
        s_wait = mod_wait;
      end
      default: begin
        s_kind = mpr_pkg::K_DES;
      end
    endcase
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= H_IDLE;
      op_r <= mpr_pkg::OP_ENTER;
      more_r <= 1'b0;
      cnt_r <= 8'h00;
    end else begin
      unique case (state_r)
        H_IDLE: begin
          if (accept) begin
            state_r <= H_WAIT;
            op_r <= op_sel;
            more_r <= s_more;
            cnt_r <= s_wait;
          end
        end
        H_WAIT: begin
          if (step_end) begin
            if (more_r) begin
              more_r <= s_more;
              cnt_r <= s_wait;
            end else begin
              state_r <= H_IDLE;
            end
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // every cycle without a new step is a deselect
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_r <= mpr_pkg::cmd_enc(mpr_pkg::K_DES);
      sel_r <= 4'h0;
      addr_r <= 14'h0000;
    end else if (issue) begin
      cmd_r <= mpr_pkg::cmd_enc(s_kind);
      sel_r <= s_sel;
      addr_r <= s_addr;
    end else begin
      cmd_r <= mpr_pkg::cmd_enc(mpr_pkg::K_DES);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mpr_on_r <= 1'b0;
    end else if (step_end && !more_r && op_r == mpr_pkg::OP_ENTER) begin
      mpr_on_r <= 1'b1;
    end else if (step_end && more_r && op_r == mpr_pkg::OP_EXIT) begin
      mpr_on_r <= 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_bl_r <= `BL_FIX8;
      cfg_fmt_r <= 2'h0;
      cfg_cal_r <= 1'b0;
      cfg_dll_r <= 1'b0;
      cfg_rl_r <= 6'h00;
    end else if (reg_wr && reg_addr == `REG_CFG) begin
      cfg_bl_r <= reg_wdata[`CFG_BL_HI:`CFG_BL_LO];
      cfg_fmt_r <= reg_wdata[`CFG_FMT_HI:`CFG_FMT_LO];
      cfg_cal_r <= reg_wdata[`CFG_CAL];
      cfg_dll_r <= reg_wdata[`CFG_DLL];
      cfg_rl_r <= reg_wdata[`CFG_RL_HI:`CFG_RL_LO];
    end
  end

  // a refusal in the clearing cycle still sticks
  always_ff @(posedge clk) begin
    if (!nrst) begin
      refused_r <= 1'b0;
    end else if (refuse) begin
      refused_r <= 1'b1;
    end else if (reg_wr && reg_addr == `REG_STAT && reg_wdata[`STAT_REFUSED]) begin
      refused_r <= 1'b0;
    end
  end

  // capture samples while the dram drives its strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lane_r <= 8'h00;
      beat0_r <= 8'h00;
      beats_r <= 4'h0;
    end else if (accept && op_sel == mpr_pkg::OP_READ) begin
      lane_r <= 8'h00;
      beats_r <= 4'h0;
    end else if (state_r == H_WAIT && op_r == mpr_pkg::OP_READ && link.dqs_act) begin
      lane_r <= {lane_r[6:0], link.dq[0]};
      if (beats_r == 4'h0) begin
        beat0_r <= link.dq;
      end
      beats_r <= beats_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CFG: reg_rdata <= {18'h00000, cfg_rl_r, 2'h0, cfg_dll_r, cfg_cal_r,
                                cfg_fmt_r, cfg_bl_r};
        `REG_STAT: reg_rdata <= {29'h00000000, refused_r, mpr_on_r,
                                 state_r != H_IDLE};
        `REG_RDATA: reg_rdata <= {12'h000, beats_r, beat0_r, lane_r};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ****************************************
  // pins
  // ****************************************
  assign link.cke = 1'b1;
  assign link.cs_n = cmd_r.cs_n;
  assign link.act_n = cmd_r.act_n;
  assign link.ras_n = cmd_r.ras_n;
  assign link.cas_n = cmd_r.cas_n;
  assign link.we_n = cmd_r.we_n;
  assign link.bg = sel_r[3:2];
  assign link.ba = sel_r[1:0];
  assign link.addr = addr_r;
endmodule : mpr_ctrl_end
`default_nettype wire

// ---- verification/mpr_link_monitor.sv ----
// assertion checker on the command and data wires of the mpr link
`timescale 1ns/1ps
`default_nettype none
module mpr_link_monitor #(
  parameter int RL = 6
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic act_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [13:0] addr,
  input wire logic dq_oe,
  input wire logic dqs_o,
  input wire logic dqs_oe
);
  // ***
  // command decode and refresh gap
  // ***
  localparam int RLM = RL - 1;
  logic sel, rd, mrs, rfr, pre;
  logic ref_r;
  logic [5:0] gap_r;
  assign sel = !cs_n && act_n;
  assign rd = sel && {ras_n, cas_n, we_n} == 3'h5;
  assign mrs = sel && {ras_n, cas_n, we_n} == 3'h0;
  assign rfr = sel && {ras_n, cas_n, we_n} == 3'h1;
  assign pre = sel && {ras_n, cas_n, we_n} == 3'h2 && addr[10];
  // saturating, so a long idle never wraps into a false short gap
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gap_r <= 6'h00;
      ref_r <= 1'b0;
    end else if (!cs_n) begin
      gap_r <= 6'h00;
      ref_r <= rfr;
    end else if (gap_r != 6'h3F) begin
      gap_r <= gap_r + 6'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_cke; cke; endproperty
  a_cke: assert property (p_cke) else $error("cke dropped");
  property p_one; !cs_n |=> cs_n; endproperty
  a_one: assert property (p_one) else $error("command not single");
  property p_mrs; mrs |-> bg == 2'h0 && (ba == 2'h3 || ba == 2'h0); endproperty
  a_mrs: assert property (p_mrs) else $error("mode write decode");
  property p_entry; mrs && ba == 2'h3 && addr[2] |-> $past(pre, 3); endproperty
  a_entry: assert property (p_entry) else $error("entry without precharge");
  property p_lat; rd |=> !dq_oe ##RLM dq_oe; endproperty
  a_lat: assert property (p_lat) else $error("read latency");
  property p_col; rd |-> addr[1:0] == 2'h0; endproperty
  a_col: assert property (p_col) else $error("read column");
  property p_burst;
    $rose(dq_oe) |-> dq_oe [*4] ##1 (!dq_oe or (dq_oe [*4] ##1 !dq_oe));
  endproperty
  a_burst: assert property (p_burst) else $error("burst length");
  property p_dqs; $rose(dq_oe) |-> dqs_oe && dqs_o ##1 dqs_oe && !dqs_o; endproperty
  a_dqs: assert property (p_dqs) else $error("strobe with data");
  property p_ref; !cs_n && ref_r |-> gap_r >= 6'h27; endproperty
  a_ref: assert property (p_ref) else $error("refresh gap");
endmodule : mpr_link_monitor
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench: both link ends driven through the register port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ***
  // signals and instances
  // ***
  logic clk, nrst, reg_wr, reg_rd, mpr_on;
  logic [1:0] fmt;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] dflt [4] = '{8'h55, 8'h33, 8'h0F, 8'h00};
  logic [7:0] wpat [4] = '{8'hA5, 8'h96, 8'hC3, 8'h81};
  logic [31:0] tcfg [7] = '{32'h620, 32'h620, 32'h622, 32'h622, 32'h624, 32'h628, 32'h621};
  logic [31:0] tcmd [7] = '{32'h02, 32'h32, 32'h02, 32'h42, 32'h02, 32'h12, 32'h22};
  logic [31:0] texp [7] = '{32'h8FFA5, 32'h8FF81, 32'h4FF0A, 32'h40005, 32'h8A5FF,
                            32'h8FF96, 32'h8FFC3};
  mpr_link_if link ();
  mpr_ctrl_end u_mpr_ctrl_end (.clk(clk), .nrst(nrst), .link(link.ctrl),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  // latency inputs fixed: read latency 1 + 4 + 1 = 6, matching cfg rl
  mpr_dram_end u_mpr_dram_end (.clk(clk), .nrst(nrst), .link(link.dram),
    .cas_lat(5'h04), .add_lat(5'h01), .par_lat(3'h1), .par_en(1'b1),
    .mpr_on(mpr_on), .fmt(fmt));
  mpr_link_monitor #(.RL(6)) u_mpr_link_monitor (.clk(clk), .nrst(nrst),
    .cke(link.cke), .cs_n(link.cs_n), .act_n(link.act_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .bg(link.bg), .ba(link.ba),
    .addr(link.addr), .dq_oe(link.dq_oe), .dqs_o(link.dqs_o), .dqs_oe(link.dqs_oe));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      stop_test();
    end
  end
  // ***
  // tasks
  // ***
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rchk
  // polls busy under a bound so a stuck sequencer cannot hang the run
  task automatic cmd(input logic [31:0] c);
    logic b;
    wr(4'h0, c);
    b = 1'b1;
    for (int i = 0; i < 60 && b !== 1'b0; i++) begin
      @(posedge clk);
      reg_addr <= 4'h8;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 b = reg_rdata[0];
    end
    chk({31'h0, b}, 32'h0);
  endtask : cmd
  // ***
  // sequence
  // ***
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rchk(4'h8, 32'h0);
    wr(4'h1, 32'hFFFFFFFF);
    rchk(4'h1, 32'h0);
    wr(4'h0, 32'h2);
    rchk(4'h8, 32'h4);
    wr(4'h8, 32'h4);
    wr(4'h4, 32'h620);
    rchk(4'h4, 32'h620);
    cmd(32'h0);
    rchk(4'h8, 32'h2);
    chk({31'h0, mpr_on}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      cmd({26'h0, i[1:0], 4'h2});
      rchk(4'hC, {16'h8, 8'h00, dflt[i]});
    end
    for (int i = 0; i < 4; i++) begin
      cmd({16'h0, wpat[i], 2'h0, i[1:0], 4'h3});
    end
    for (int i = 0; i < 7; i++) begin
      wr(4'h4, tcfg[i]);
      cmd(32'h5);
      cmd(32'h1);
      cmd(32'h0);
      chk({30'h0, fmt}, {30'h0, tcfg[i][3:2]});
      cmd(tcmd[i]);
      rchk(4'hC, texp[i]);
    end
    cmd(32'h4);
    cmd(32'h1);
    rchk(4'h8, 32'h0);
    // with cal on a mode write keeps the sequencer busy three cycles longer
    wr(4'h4, 32'h630);
    wr(4'h0, 32'h5);
    repeat (24) @(posedge clk);
    rchk(4'h8, 32'h1);
    wr(4'h4, 32'h623);
    wr(4'h0, 32'h5);
    rchk(4'h8, 32'h4);
    // second reset mid-run must bring the defaults back
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wr(4'h4, 32'h620);
    cmd(32'h0);
    cmd(32'h12);
    rchk(4'hC, 32'h80033);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
